// file: core/eag_defs.svh
/*
 * Constants for the effective-address generator: widths, fill patterns,
 * size steps. Assumes inclusion by core files only.
 */
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

`define ADDR_W        24
`define FILL_ONES_8   8'hFF
`define FILL_ZERO_8   8'h00
`define STEP_BYTE     32'h0000_0001
`define STEP_WORD     32'h0000_0002
`define STEP_LONG     32'h0000_0004
`define LOW_ADDR_MASK 24'hFF_FFFE
`define BYTE_SEL_MSB  3
`define BIT_NUM_W     3
`define TRAP_NUM_W    2

`endif

// file: core/eag_pkg.sv
/*
 * Types shared by the effective-address generator and its users.
 * Assumes the defs header is on the include path.
 */
package eag_pkg;

	typedef enum logic [3:0]
	{
		mode_reg_direct,
		mode_reg_indirect,
		mode_disp16,
		mode_disp32,
		mode_post_inc,
		mode_pre_dec,
		mode_abs8,
		mode_abs16,
		mode_abs24,
		mode_abs32,
		mode_immediate,
		mode_pc_rel8,
		mode_pc_rel16,
		mode_mem_indirect
	} ea_mode_t;

	typedef enum logic [1:0]
	{
		size_byte,
		size_word,
		size_long
	} op_size_t;

	typedef enum logic [2:0]
	{
		class_arith_logic,
		class_transfer,
		class_bit_manip,
		class_branch,
		class_jump,
		class_trap,
		class_implied_const
	} insn_class_t;

	typedef struct packed
	{
		logic        valid;
		insn_class_t insn_class;
		ea_mode_t    mode;
		op_size_t    size;
		logic [3:0]  general_register_field;
		logic [31:0] extension;
		logic        fetch_target;
		logic        bit_num_from_reg;
		logic [2:0]  bit_num_imm;
		logic [1:0]  trap_num;
		logic [1:0]  implied_const;
	} ea_request_t;

	typedef struct packed
	{
		logic        valid;
		logic        illegal_mode;
		logic        is_memory;
		logic [23:0] address;
		logic [31:0] operand;
		logic        writeback;
		logic [2:0]  writeback_reg;
		logic [31:0] writeback_value;
		logic        mem_indirect_read;
		logic [2:0]  bit_number;
		logic [1:0]  trap_vector;
	} ea_result_t;

endpackage : eag_pkg

// file: core/effective_address_generator.sv
/*
 * Effective-address generator: turns one decoded addressing request into
 * an operand or branch address, an immediate operand and an optional
 * register write-back. Assumes the decoder holds req for one cycle per
 * request and the register file is read combinationally via regs.
 */
`timescale 1ns/10ps
`include "eag_defs.svh"

// Summary of operation
// - register field picks byte, word or long register
// - indirect address is register; every address drops the top byte
// - displacement added, 16-bit one sign-extended
// - post-increment uses register, then add_implied_constant_instruction 1/2/4
// - pre-decrement subtracts 1/2/4, uses and stores it
// - 8-bit absolute fills upper bits with ones
// - 16-bit absolute is sign-extended
// - 24-bit absolute is fetch target, top zero
// - 32-bit absolute reaches whole address space
// - immediate operand 8/16/32 bits or implied constant
// - trap carries 2-bit vector selector
// - bit ops: direct/indirect/absolute, bit number source
// - arith only direct/immediate; transfers exclude PC-relative/memory indirect
// - PC-relative sign-extends, 24-bit target, top zero
// - relative base is next instruction address
// - memory indirect zero-extends 8-bit table address
// - odd word/long/branch address forced even

module effective_address_generator
(
	input  wire logic                 mclk,
	input  wire logic                 reset_n,
	input  wire eag_pkg::ea_request_t req,
	input  wire logic [7:0][31:0]     regs,
	input  wire logic [23:0]          next_pc,
	output eag_pkg::ea_result_t       result
);
	import eag_pkg::*;

	//****************************************************************
	// helpers
	//****************************************************************
	function automatic logic [31:0] size_step(input op_size_t s);
		case (s)
			size_byte: size_step = `STEP_BYTE;
			size_word: size_step = `STEP_WORD;
			default:   size_step = `STEP_LONG;
		endcase
	endfunction : size_step

	function automatic logic [23:0] align(input logic [23:0] a, input logic even);
		align = even ? (a & `LOW_ADDR_MASK) : a;
	endfunction : align

	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction : sext16

	function automatic logic [31:0] sext8(input logic [7:0] v);
		sext8 = {{24{v[7]}}, v};
	endfunction : sext8

	function automatic logic mode_legal(input insn_class_t c, input ea_mode_t m);
		case (c)
			class_arith_logic:
				mode_legal = (m == mode_reg_direct) || (m == mode_immediate);
			class_transfer:
				mode_legal = !(m inside {mode_pc_rel8, mode_pc_rel16, mode_mem_indirect});
			class_bit_manip:
				mode_legal = m inside {mode_reg_direct, mode_reg_indirect,
					mode_abs8, mode_abs16, mode_abs32};
			class_branch:
				mode_legal = m inside {mode_pc_rel8, mode_pc_rel16};
			class_jump:
				mode_legal = m inside {mode_reg_indirect, mode_abs24, mode_mem_indirect};
			class_trap, class_implied_const:
				mode_legal = (m == mode_immediate);
			default:
				mode_legal = 1'b0;
		endcase
	endfunction : mode_legal

	//****************************************************************
	// combinational address calculation
	//****************************************************************
	logic [2:0]  reg_idx;
	logic [31:0] full_address_register;
	logic [31:0] step;
	logic [31:0] dec_value;
	logic [31:0] inc_value;
	logic [31:0] next_operand;
	logic [31:0] raw_addr;
	logic        next_is_memory;
	logic        next_wb;
	logic [31:0] next_wb_value;
	logic        next_even;
	logic        is_fetch;

	assign reg_idx               = req.general_register_field[2:0];
	assign full_address_register = regs[reg_idx];
	assign step                  = size_step(req.size);
	assign dec_value             = full_address_register - step;
	assign inc_value             = full_address_register + step;
	assign is_fetch = req.fetch_target || (req.insn_class inside {class_branch, class_jump});

	// register-direct operand: nibble msb picks low/extended halves
	always_comb
	begin
		next_operand = '0;
		case (req.size)
			size_byte:
				next_operand = req.general_register_field[`BYTE_SEL_MSB] ?
					{24'h00_0000, regs[reg_idx][7:0]} :
					{24'h00_0000, regs[reg_idx][15:8]};
			size_word:
				next_operand = req.general_register_field[`BYTE_SEL_MSB] ?
					{16'h0000, regs[reg_idx][31:16]} :
					{16'h0000, regs[reg_idx][15:0]};
			default:
				next_operand = full_address_register;
		endcase
		if (req.mode == mode_immediate)
		begin
			if (req.insn_class == class_implied_const)
				next_operand = {30'h0000_0000, req.implied_const};
			else
				case (req.size)
					size_byte: next_operand = {24'h00_0000, req.extension[7:0]};
					size_word: next_operand = {16'h0000, req.extension[15:0]};
					default:   next_operand = req.extension;
				endcase
		end
	end

	always_comb
	begin
		raw_addr       = '0;
		next_is_memory = 1'b1;
		next_wb        = 1'b0;
		next_wb_value  = '0;
		case (req.mode)
			mode_reg_direct, mode_immediate:
				next_is_memory = 1'b0;
			mode_reg_indirect:
				raw_addr = full_address_register;
			mode_disp16:
				raw_addr = full_address_register + sext16(req.extension[15:0]);
			mode_disp32:
				raw_addr = full_address_register + req.extension;
			mode_post_inc:
			begin
				raw_addr      = full_address_register;
				next_wb       = 1'b1;
				next_wb_value = inc_value;
			end
			mode_pre_dec:
			begin
				raw_addr      = dec_value;
				next_wb       = 1'b1;
				next_wb_value = dec_value;
			end
			mode_abs8:
				raw_addr = {`FILL_ONES_8, `FILL_ONES_8, `FILL_ONES_8, req.extension[7:0]};
			mode_abs16:
				raw_addr = sext16(req.extension[15:0]);
			mode_abs24:
				raw_addr = {`FILL_ZERO_8, req.extension[23:0]};
			mode_abs32:
				raw_addr = req.extension;
			mode_pc_rel8:
				raw_addr = {`FILL_ZERO_8, next_pc} + sext8(req.extension[7:0]);
			mode_pc_rel16:
				raw_addr = {`FILL_ZERO_8, next_pc} + sext16(req.extension[15:0]);
			mode_mem_indirect:
				raw_addr = {24'h00_0000, req.extension[7:0]};
			default:
				next_is_memory = 1'b0;
		endcase
	end

	// byte data may sit at odd addresses; everything else is forced even
	// relative targets are branch targets whatever class the decoder gives
	assign next_even = is_fetch || (req.size != size_byte)
		|| (req.mode inside {mode_mem_indirect, mode_pc_rel8, mode_pc_rel16});

	//****************************************************************
	// registered result
	//****************************************************************
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			result <= '0;
		else
		begin
			result.valid             <= req.valid;
			result.illegal_mode      <= req.valid && !mode_legal(req.insn_class, req.mode);
			result.is_memory         <= next_is_memory;
			// only 24 address lines exist, so every address loses the top byte
			result.address           <= align(raw_addr[`ADDR_W-1:0], next_even);
			result.operand           <= next_operand;
			// a refused mode must not disturb the register file
			result.writeback         <= req.valid && next_wb
				&& mode_legal(req.insn_class, req.mode);
			result.writeback_reg     <= reg_idx;
			result.writeback_value   <= next_wb_value;
			result.mem_indirect_read <= req.valid && (req.mode == mode_mem_indirect);
			result.bit_number        <= req.bit_num_from_reg ?
				full_address_register[`BIT_NUM_W-1:0] : req.bit_num_imm;
			result.trap_vector       <= req.trap_num[`TRAP_NUM_W-1:0];
		end
	end

	//****************************************************************
	// assertions
	//****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	//****************************************************************
	// assertions: register operands and immediates
	//****************************************************************
	reg_byte_lo_a: assert property (req.valid && req.mode == mode_reg_direct
		&& req.size == size_byte && req.general_register_field[`BYTE_SEL_MSB]
		|=> result.operand == {24'h00_0000, $past(full_address_register[7:0])})
		else $error("low byte register operand wrong");
	reg_word_hi_a: assert property (req.valid && req.mode == mode_reg_direct
		&& req.size == size_word && req.general_register_field[`BYTE_SEL_MSB]
		|=> result.operand == {16'h0000, $past(full_address_register[31:16])})
		else $error("extended word register operand wrong");
	direct_no_mem_a: assert property (req.valid
		&& req.mode inside {mode_reg_direct, mode_immediate}
		|=> !result.is_memory)
		else $error("register or immediate operand marked as memory");
	imm_byte_a: assert property (req.valid && req.mode == mode_immediate
		&& req.insn_class == class_arith_logic && req.size == size_byte
		|=> result.operand == {24'h00_0000, $past(req.extension[7:0])})
		else $error("byte immediate wrong");
	imm_word_a: assert property (req.valid && req.mode == mode_immediate
		&& req.insn_class == class_arith_logic && req.size == size_word
		|=> result.operand == {16'h0000, $past(req.extension[15:0])})
		else $error("word immediate wrong");
	implied_const_a: assert property (req.valid && req.mode == mode_immediate
		&& req.insn_class == class_implied_const
		|=> result.operand == {30'h0000_0000, $past(req.implied_const)})
		else $error("implied constant wrong");
	trap_vec_a: assert property (req.valid
		|=> result.trap_vector == $past(req.trap_num))
		else $error("trap vector lost");
	bit_num_src_a: assert property (req.valid
		|=> result.bit_number == ($past(req.bit_num_from_reg) ?
		$past(full_address_register[`BIT_NUM_W-1:0]) : $past(req.bit_num_imm)))
		else $error("bit number source wrong");

	//****************************************************************
	// assertions: data addresses
	//****************************************************************
	// $past sees the register file before a write-back of the same edge lands
	reg_indirect_addr_a: assert property (req.valid && req.mode == mode_reg_indirect
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(full_address_register[`ADDR_W-1:0]))
		else $error("indirect address wrong");
	disp16_sum_a: assert property (req.valid && req.mode == mode_disp16
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(full_address_register[`ADDR_W-1:0]
		+ {{8{req.extension[15]}}, req.extension[15:0]}))
		else $error("16-bit displacement sum wrong");
	disp32_sum_a: assert property (req.valid && req.mode == mode_disp32
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(full_address_register[`ADDR_W-1:0]
		+ req.extension[`ADDR_W-1:0]))
		else $error("32-bit displacement sum wrong");
	post_inc_step_a: assert property (req.valid && req.mode == mode_post_inc
		&& mode_legal(req.insn_class, req.mode)
		|=> result.writeback && result.writeback_value == $past(inc_value))
		else $error("post-increment write-back wrong");
	post_inc_addr_a: assert property (req.valid && req.mode == mode_post_inc
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(full_address_register[`ADDR_W-1:0]))
		else $error("post-increment address wrong");
	pre_dec_addr_a: assert property (req.valid && req.mode == mode_pre_dec
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(dec_value[23:0])
		&& result.writeback_value == $past(dec_value))
		else $error("pre-decrement address mismatch");
	step_reg_a: assert property (req.valid
		&& req.mode inside {mode_post_inc, mode_pre_dec}
		|=> result.writeback_reg == $past(reg_idx))
		else $error("write-back register wrong");
	no_step_wb_a: assert property (req.valid
		&& !(req.mode inside {mode_post_inc, mode_pre_dec}) |=> !result.writeback)
		else $error("write-back without auto step");
	abs8_fill_a: assert property (req.valid && req.mode == mode_abs8
		|=> result.address[23:8] == 16'hFFFF)
		else $error("abs8 upper bits not ones");
	abs16_sext_a: assert property (req.valid && req.mode == mode_abs16
		|=> result.address[23:16] == {8{result.address[15]}})
		else $error("abs16 not sign-extended");
	abs32_whole_a: assert property (req.valid && req.mode == mode_abs32
		&& req.size == size_byte && !is_fetch
		|=> result.address == $past(req.extension[`ADDR_W-1:0]))
		else $error("32-bit absolute address wrong");
	byte_odd_a: assert property (req.valid && req.mode == mode_abs8
		&& req.size == size_byte && !is_fetch |=> result.address[0] == $past(req.extension[0]))
		else $error("byte address made even");
	even_word_a: assert property (req.valid && req.size != size_byte
		&& req.mode != mode_reg_direct |=> !result.address[0])
		else $error("word address odd");

	//****************************************************************
	// assertions: fetch targets and refused modes
	//****************************************************************
	abs24_fetch_a: assert property (req.valid && req.mode == mode_abs24
		&& req.insn_class == class_jump
		|=> result.address == ($past(req.extension[`ADDR_W-1:0]) & `LOW_ADDR_MASK))
		else $error("24-bit jump target wrong");
	pc_rel_target_a: assert property (req.valid && req.mode == mode_pc_rel8
		|=> result.address == (($past(next_pc)
		+ {{16{$past(req.extension[7])}}, $past(req.extension[7:0])}) & 24'hFF_FFFE))
		else $error("relative branch target wrong");
	rel16_target_a: assert property (req.valid && req.mode == mode_pc_rel16
		|=> result.address == (($past(next_pc)
		+ {{8{$past(req.extension[15])}}, $past(req.extension[15:0])}) & `LOW_ADDR_MASK))
		else $error("long relative branch target wrong");
	fetch_even_a: assert property (req.valid && is_fetch && next_is_memory
		|=> !result.address[0])
		else $error("fetch target odd");
	mem_ind_range_a: assert property (req.valid && req.mode == mode_mem_indirect
		|=> result.mem_indirect_read && result.address[23:8] == 16'h0000)
		else $error("memory indirect out of range");
	arith_mode_a: assert property (req.valid && req.insn_class == class_arith_logic
		&& req.mode == mode_abs16 |=> result.illegal_mode)
		else $error("arith illegal mode accepted");
	refused_wb_a: assert property (req.valid && !mode_legal(req.insn_class, req.mode)
		|=> result.illegal_mode && !result.writeback)
		else $error("refused mode still writes back");

	post_inc_c: cover property (req.valid && req.mode == mode_post_inc);
	pre_dec_c:  cover property (req.valid && req.mode == mode_pre_dec && req.size == size_long);
	branch_c:   cover property (req.valid && req.mode == mode_pc_rel16);
	implied_c:  cover property (req.valid && req.insn_class == class_implied_const);
	illegal_c:  cover property (result.illegal_mode);

endmodule : effective_address_generator

// file: testbench/register_file_model.sv
/*
 * Register file standing in for the decoder side of the address generator.
 * Assumes one writer per edge: a preload from the bench or a write-back.
 */
`timescale 1ns/10ps

module register_file_model
(
	input  wire logic                mclk,
	input  wire logic                reset_n,
	input  wire eag_pkg::ea_result_t result,
	input  wire logic                load_en,
	input  wire logic [2:0]          load_idx,
	input  wire logic [31:0]         load_val,
	output logic [7:0][31:0]         regs
);
	import eag_pkg::*;

	// write-back lands one edge after the result, so callers leave a gap
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			regs <= '0;
		else if (load_en)
			regs[load_idx] <= load_val;
		else if (result.writeback)
			regs[result.writeback_reg] <= result.writeback_value;
	end
endmodule : register_file_model

// file: testbench/effective_address_generator_test.sv
/*
 * Self-checking bench for the effective-address generator.
 * Assumes one-cycle result latency and the register file model beside it.
 */
`timescale 1ns/10ps
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end end

module effective_address_generator_test;
	import eag_pkg::*;
	logic             mclk = 1'b0;
	logic             reset_n = 1'b0;
	ea_request_t      req = '0;
	logic [7:0][31:0] regs;
	logic [23:0]      next_pc = 24'h00_0000;
	ea_result_t       result;
	logic             load_en = 1'b0;
	logic [2:0]       load_idx = 3'h0;
	logic [31:0]      load_val = 32'h0000_0000;
	int               n_errors = 0;
	int               checks_done = 0;

	always #20 mclk = ~mclk;

	effective_address_generator u_effective_address_generator
	(.mclk(mclk), .reset_n(reset_n), .req(req), .regs(regs), .next_pc(next_pc), .result(result));

	register_file_model u_register_file_model
	(.mclk(mclk), .reset_n(reset_n), .result(result), .load_en(load_en),
	 .load_idx(load_idx), .load_val(load_val), .regs(regs));

	// ****************************************
	// shared tasks
	// ****************************************
	task end_sim;
	begin
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask : end_sim

	function automatic ea_request_t mk(insn_class_t c, ea_mode_t m, op_size_t s,
		logic [3:0] f, logic [31:0] x);
		mk = '0;
		mk.valid = 1'b1;
		mk.insn_class = c;
		mk.mode = m;
		mk.size = s;
		mk.general_register_field = f;
		mk.extension = x;
	endfunction : mk

	task load(input logic [2:0] i, input logic [31:0] v);
	begin
		@(negedge mclk);
		load_en = 1'b1;
		load_idx = i;
		load_val = v;
		@(negedge mclk);
		load_en = 1'b0;
	end
	endtask : load

	// result is due exactly one edge after the request is taken
	task issue(input ea_request_t r);
	begin
		@(negedge mclk);
		req = r;
		@(negedge mclk);
		req.valid = 1'b0;
		`CHECK_EQ(result.valid, 1'b1)
		if (result.valid !== 1'b1)
			end_sim;
	end
	endtask : issue

	task t_reset;
	begin
		`CHECK_EQ(result, ea_result_t'(0))
	end
	endtask : t_reset

	task t_auto_step;
	begin
		load(3'h2, 32'h0000_0100);
		issue(mk(class_transfer, mode_post_inc, size_word, 4'h2, 32'h0));
		`CHECK_EQ(result.address, 24'h00_0100)
		`CHECK_EQ({result.writeback, result.writeback_reg}, 4'hA)
		`CHECK_EQ(result.writeback_value, 32'h0000_0102)
		issue(mk(class_transfer, mode_post_inc, size_word, 4'h2, 32'h0));
		`CHECK_EQ(result.address, 24'h00_0102)
		load(3'h3, 32'h0000_2000);
		issue(mk(class_transfer, mode_pre_dec, size_long, 4'h3, 32'h0));
		`CHECK_EQ(result.address, 24'h00_1FFC)
		`CHECK_EQ(result.writeback_value, 32'h0000_1FFC)
		load(3'h4, 32'h0000_0011);
		issue(mk(class_transfer, mode_post_inc, size_byte, 4'h4, 32'h0));
		`CHECK_EQ(result.address, 24'h00_0011)
		`CHECK_EQ(result.writeback_value, 32'h0000_0012)
		issue(mk(class_transfer, mode_pre_dec, size_byte, 4'h4, 32'h0));
		`CHECK_EQ(result.address, 24'h00_0011)
	end
	endtask : t_auto_step

	task t_absolute;
	begin
		issue(mk(class_transfer, mode_abs8, size_byte, 4'h0, 32'h0000_0085));
		`CHECK_EQ(result.address, 24'hFF_FF85)
		issue(mk(class_transfer, mode_abs16, size_word, 4'h0, 32'h0000_8000));
		`CHECK_EQ(result.address, 24'hFF_8000)
		issue(mk(class_transfer, mode_abs16, size_byte, 4'h0, 32'h0000_7FFF));
		`CHECK_EQ(result.address, 24'h00_7FFF)
		issue(mk(class_transfer, mode_abs32, size_byte, 4'h0, 32'h00AB_CDEF));
		`CHECK_EQ(result.address, 24'hAB_CDEF)
		issue(mk(class_jump, mode_abs24, size_long, 4'h0, 32'h0012_3457));
		`CHECK_EQ(result.address, 24'h12_3456)
	end
	endtask : t_absolute

	task t_indirect;
		ea_request_t r;
	begin
		load(3'h5, 32'h0000_1000);
		issue(mk(class_transfer, mode_disp16, size_byte, 4'h5, 32'h0000_FFF0));
		`CHECK_EQ(result.address, 24'h00_0FF0)
		issue(mk(class_transfer, mode_disp32, size_byte, 4'h5, 32'h0001_0001));
		`CHECK_EQ(result.address, 24'h01_1001)
		load(3'h6, 32'hAB00_2001);
		issue(mk(class_jump, mode_reg_indirect, size_long, 4'h6, 32'h0));
		`CHECK_EQ(result.address, 24'h00_2000)
		issue(mk(class_transfer, mode_reg_indirect, size_byte, 4'h6, 32'h0));
		`CHECK_EQ({result.is_memory, result.address}, {1'b1, 24'h00_2001})
		r = mk(class_transfer, mode_reg_indirect, size_byte, 4'h6, 32'h0);
		r.fetch_target = 1'b1;
		issue(r);
		`CHECK_EQ(result.address, 24'h00_2000)
		issue(mk(class_jump, mode_mem_indirect, size_long, 4'h0, 32'h0000_0085));
		`CHECK_EQ(result.address, 24'h00_0084)
		`CHECK_EQ(result.mem_indirect_read, 1'b1)
	end
	endtask : t_indirect

	task t_pc_relative;
	begin
		next_pc = 24'h00_0100;
		issue(mk(class_branch, mode_pc_rel8, size_byte, 4'h0, 32'h0000_0080));
		`CHECK_EQ(result.address, 24'h00_0080)
		issue(mk(class_branch, mode_pc_rel8, size_byte, 4'h0, 32'h0000_0081));
		`CHECK_EQ(result.address, 24'h00_0080)
		next_pc = 24'h01_0000;
		issue(mk(class_branch, mode_pc_rel16, size_word, 4'h0, 32'h0000_7FFF));
		`CHECK_EQ(result.address, 24'h01_7FFE)
	end
	endtask : t_pc_relative

	task t_operands;
		ea_request_t r;
	begin
		load(3'h1, 32'h1234_5678);
		issue(mk(class_arith_logic, mode_reg_direct, size_byte, 4'h1, 32'h0));
		`CHECK_EQ(result.operand[7:0], 8'h56)
		`CHECK_EQ(result.is_memory, 1'b0)
		issue(mk(class_arith_logic, mode_reg_direct, size_byte, 4'h9, 32'h0));
		`CHECK_EQ(result.operand[7:0], 8'h78)
		issue(mk(class_arith_logic, mode_reg_direct, size_word, 4'h9, 32'h0));
		`CHECK_EQ(result.operand[15:0], 16'h1234)
		issue(mk(class_arith_logic, mode_immediate, size_long, 4'h0, 32'hDEAD_BEEF));
		`CHECK_EQ(result.operand, 32'hDEAD_BEEF)
		issue(mk(class_arith_logic, mode_immediate, size_word, 4'h0, 32'h0001_BEEF));
		`CHECK_EQ(result.operand, 32'h0000_BEEF)
		r = mk(class_implied_const, mode_immediate, size_long, 4'h0, 32'h0000_0004);
		r.implied_const = 2'h2;
		issue(r);
		`CHECK_EQ(result.operand, 32'h0000_0002)
		load(3'h7, 32'h0000_0006);
		r = mk(class_bit_manip, mode_reg_direct, size_byte, 4'h7, 32'h0);
		r.bit_num_from_reg = 1'b1;
		r.bit_num_imm = 3'h3;
		issue(r);
		`CHECK_EQ(result.bit_number, 3'h6)
		for (int i = 0; i < 4; i++)
		begin
			r = mk(class_trap, mode_immediate, size_byte, 4'h0, 32'h0);
			r.trap_num = 2'(i);
			issue(r);
			`CHECK_EQ(result.trap_vector, 2'(i))
		end
		r = mk(class_bit_manip, mode_abs8, size_byte, 4'h0, 32'h0000_0010);
		r.bit_num_imm = 3'h5;
		issue(r);
		`CHECK_EQ(result.bit_number, 3'h5)
	end
	endtask : t_operands

	task t_illegal;
	begin
		issue(mk(class_arith_logic, mode_post_inc, size_word, 4'h2, 32'h0));
		`CHECK_EQ({result.illegal_mode, result.writeback}, 2'b10)
		issue(mk(class_transfer, mode_pc_rel8, size_byte, 4'h0, 32'h0000_0002));
		`CHECK_EQ(result.illegal_mode, 1'b1)
		issue(mk(class_transfer, mode_mem_indirect, size_long, 4'h0, 32'h0000_0010));
		`CHECK_EQ(result.illegal_mode, 1'b1)
		issue(mk(class_bit_manip, mode_disp16, size_byte, 4'h5, 32'h0000_0004));
		`CHECK_EQ(result.illegal_mode, 1'b1)
		issue(mk(class_arith_logic, mode_immediate, size_byte, 4'h0, 32'h0000_0007));
		`CHECK_EQ(result.illegal_mode, 1'b0)
	end
	endtask : t_illegal

	initial
	begin
		repeat (4) @(negedge mclk);
		t_reset;
		reset_n = 1'b1;
		@(negedge mclk);
		t_reset;
		t_auto_step;
		t_absolute;
		t_indirect;
		t_pc_relative;
		t_operands;
		t_illegal;
		end_sim;
	end
endmodule : effective_address_generator_test
